// file: pkg/cbcfg_defs.svh
/*
 Byte indices, field positions and reset values of the upper configuration
 bytes of the clock buffer. Assumes inclusion by the package and the RTL.
*/
`ifndef CBCFG_DEFS_SVH
`define CBCFG_DEFS_SVH
`define CBCFG_IDX_FREQ      8'h03
`define CBCFG_IDX_RSVD      8'h04
`define CBCFG_IDX_REVVEN    8'h05
`define CBCFG_IDX_PART      8'h06
`define CBCFG_IDX_LEN       8'h07
`define CBCFG_FREQ_RST      8'h07
`define CBCFG_FREQ_WMASK    8'h39
`define CBCFG_RSVD_VAL      8'hFF
`define CBCFG_LEN_RST       8'h08
`define CBCFG_LEN_WMASK     8'h1F
`define CBCFG_BIT_FSEL_EN   5
`define CBCFG_BIT_FSEL_HI   4
`define CBCFG_BIT_FSEL_LO   3
`define CBCFG_BIT_FB_EDGE   0
`define CBCFG_IDX_LAST      8'h07
`endif

// file: pkg/cbcfg_pkg.sv
/*
 Types shared by the configuration bank. Assumes cbcfg_defs.svh is on the
 include path.
*/
`include "cbcfg_defs.svh"
package cbcfg_pkg;
   typedef struct packed {
      logic       wrEn;
      logic [7:0] idx;
      logic [7:0] data;
   } cbcfg_wr_t;
   typedef struct packed {
      logic       freqSwEnable;
      logic [1:0] frequencyChoice;
      logic       feedbackEdgeRatePick;
      logic [4:0] readbackCount;
   } cbcfg_ctl_t;
endpackage

// file: rtl/cbcfg_rd_mux.sv
/*
 Combinational read-back multiplexer for byte indices 3 to 7. Assumes the
 stored bytes come from registers on the same clock.
*/
`timescale 1ns/1ps
`include "cbcfg_defs.svh"
module cbcfg_rd_mux
   import cbcfg_pkg::*;
// The identity codes below are arbitrary values; the product sets the real ones.
#(
   parameter logic [3:0] REV_CODE  = 4'hA,
   parameter logic [3:0] MAKER     = 4'h5,
   parameter logic [1:0] CLASS     = 2'h2,
   parameter logic [5:0] PART_NUM  = 6'h2A
) (
   // Selection
   input  wire logic [7:0] idx,
   // Stored bytes
   input  wire logic [7:0] freqByte,
   input  wire logic [7:0] lenByte,
   // Result
   output logic [7:0]      rdByte
);
   always_comb begin
      unique case (idx)
         `CBCFG_IDX_FREQ:   rdByte = freqByte;
         `CBCFG_IDX_RSVD:   rdByte = `CBCFG_RSVD_VAL;
         `CBCFG_IDX_REVVEN: rdByte = {REV_CODE, MAKER};
         `CBCFG_IDX_PART:   rdByte = {CLASS, PART_NUM};
         `CBCFG_IDX_LEN:    rdByte = lenByte;
         default:           rdByte = 8'h00;
      endcase
   end
endmodule // cbcfg_rd_mux

// file: rtl/cbcfg_bank.sv
/*
 Upper configuration bytes of the clock buffer and the block-read sequencer
 that feeds the serial engine. Assumes the serial engine supplies decoded
 byte writes, a block-read start with starting index, and a byte-taken
 strobe per acknowledged byte; all on clk_sys.
*/
// Overview of operation
// - Bit 5 of byte 3 enables software frequency selection, reset 0.
// - Bits 4:3 of byte 3 choose frequency, reset 0, act only when enabled.
// - Bit 0 of byte 3 picks feedback edge rate, 1 faster, reset 1.
// - Byte 4 is reserved and always reads all ones.
// - Byte 5 is read-only revision code over maker code.
// - Byte 6 is read-only part class over part number.
// - Block read sends the count first, then bytes from the start index.
`timescale 1ns/1ps
`include "cbcfg_defs.svh"
module cbcfg_bank
   import cbcfg_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst,
   // Byte writes from the serial engine
   input  wire cbcfg_wr_t  wrReq,
   // Block read control
   input  wire logic       blkStart,
   input  wire logic [7:0] blkStartIdx,
   input  wire logic       byteTaken,
   input  wire logic       hostNack,
   // Block read data
   output logic [7:0]      txByte_ff,
   output logic            txValid_ff,
   // Control towards the clock path
   output cbcfg_ctl_t      ctl_ff
);
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_COUNT = 3'b010,
      ST_DATA  = 3'b100
   } cbcfg_st_t;

   logic [7:0] freqByte_ff, nxt_freqByte;
   logic [7:0] lenByte_ff, nxt_lenByte;
   cbcfg_st_t  state_ff, nxt_state;
   logic [7:0] rdIdx_ff, nxt_rdIdx;
   logic [4:0] left_ff, nxt_left;
   logic [7:0] nxt_txByte;
   logic       nxt_txValid;
   cbcfg_ctl_t nxt_ctl;
   logic [7:0] rdByte;

   cbcfg_rd_mux u_mux (
      .idx      (rdIdx_ff),
      .freqByte (freqByte_ff),
      .lenByte  (lenByte_ff),
      .rdByte   (rdByte)
   );

   // Register bytes; masks keep reserved and read-only bits at defaults.
   always_comb begin
      nxt_freqByte = freqByte_ff;
      nxt_lenByte  = lenByte_ff;
      if (wrReq.wrEn && wrReq.idx == `CBCFG_IDX_FREQ) begin
         nxt_freqByte = (wrReq.data & `CBCFG_FREQ_WMASK)
                      | (`CBCFG_FREQ_RST & ~`CBCFG_FREQ_WMASK);
      end
      if (wrReq.wrEn && wrReq.idx == `CBCFG_IDX_LEN) begin
         nxt_lenByte = wrReq.data & `CBCFG_LEN_WMASK;
      end
   end

   // Frequency choice is forwarded only while enabled, else held at zero.
   always_comb begin
      nxt_ctl.freqSwEnable         = freqByte_ff[`CBCFG_BIT_FSEL_EN];
      nxt_ctl.frequencyChoice      = freqByte_ff[`CBCFG_BIT_FSEL_EN]
         ? {freqByte_ff[`CBCFG_BIT_FSEL_HI], freqByte_ff[`CBCFG_BIT_FSEL_LO]}
         : 2'h0;
      nxt_ctl.feedbackEdgeRatePick = freqByte_ff[`CBCFG_BIT_FB_EDGE];
      nxt_ctl.readbackCount        = lenByte_ff[4:0];
   end

   // Block-read sequencer: count byte, then count data bytes.
   always_comb begin
      nxt_state   = state_ff;
      nxt_rdIdx   = rdIdx_ff;
      nxt_left    = left_ff;
      nxt_txByte  = txByte_ff;
      nxt_txValid = txValid_ff;
      unique case (state_ff)
         ST_IDLE: begin
            if (blkStart) begin
               nxt_state   = ST_COUNT;
               nxt_rdIdx   = blkStartIdx;
               nxt_left    = lenByte_ff[4:0];
               nxt_txByte  = {3'h0, lenByte_ff[4:0]};
               nxt_txValid = 1'b1;
            end
         end
         ST_COUNT: begin
            if (hostNack) begin
               nxt_state   = ST_IDLE;
               nxt_txValid = 1'b0;
            end else if (byteTaken) begin
               if (left_ff == 5'h00) begin
                  nxt_state   = ST_IDLE;
                  nxt_txValid = 1'b0;
               end else begin
                  nxt_state  = ST_DATA;
                  nxt_txByte = rdByte;
                  nxt_rdIdx  = rdIdx_ff + 8'h01;
                  nxt_left   = left_ff - 5'h01;
               end
            end
         end
         ST_DATA: begin
            if (hostNack || (byteTaken && left_ff == 5'h00)) begin
               nxt_state   = ST_IDLE;
               nxt_txValid = 1'b0;
            end else if (byteTaken) begin
               nxt_txByte = rdByte;
               nxt_rdIdx  = rdIdx_ff + 8'h01;
               nxt_left   = left_ff - 5'h01;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         freqByte_ff <= `CBCFG_FREQ_RST;
         lenByte_ff  <= `CBCFG_LEN_RST;
         state_ff    <= ST_IDLE;
         rdIdx_ff    <= 8'h00;
         left_ff     <= 5'h00;
         txByte_ff   <= 8'h00;
         txValid_ff  <= 1'b0;
         ctl_ff      <= '0;
      end else begin
         freqByte_ff <= nxt_freqByte;
         lenByte_ff  <= nxt_lenByte;
         state_ff    <= nxt_state;
         rdIdx_ff    <= nxt_rdIdx;
         left_ff     <= nxt_left;
         txByte_ff   <= nxt_txByte;
         txValid_ff  <= nxt_txValid;
         ctl_ff      <= nxt_ctl;
      end
   end

   // Checks.
   property p_freqDisabled;
      @(posedge clk_sys) disable iff (rst)
      !freqByte_ff[`CBCFG_BIT_FSEL_EN] |=> ctl_ff.frequencyChoice == 2'h0;
   endproperty
   a_freqDisabled: assert property (p_freqDisabled) else $error("choice leaks");

   property p_enFollows;
      @(posedge clk_sys) disable iff (rst)
      wrReq.wrEn && wrReq.idx == `CBCFG_IDX_FREQ
      |=> ##1 ctl_ff.freqSwEnable == $past(wrReq.data[`CBCFG_BIT_FSEL_EN], 2);
   endproperty
   a_enFollows: assert property (p_enFollows) else $error("enable lost");

   property p_fbFollows;
      @(posedge clk_sys) disable iff (rst)
      wrReq.wrEn && wrReq.idx == `CBCFG_IDX_FREQ
      |=> ##1 ctl_ff.feedbackEdgeRatePick == $past(wrReq.data[0], 2);
   endproperty
   a_fbFollows: assert property (p_fbFollows) else $error("edge pick lost");

   property p_rsvdFreq;
      @(posedge clk_sys) disable iff (rst)
      freqByte_ff[7:6] == 2'h0 && freqByte_ff[2:1] == 2'h3;
   endproperty
   a_rsvdFreq: assert property (p_rsvdFreq) else $error("reserved bits moved");

   property p_lenRsvd;
      @(posedge clk_sys) disable iff (rst) lenByte_ff[7:5] == 3'h0;
   endproperty
   a_lenRsvd: assert property (p_lenRsvd) else $error("length high bits set");

   property p_countFirst;
      @(posedge clk_sys) disable iff (rst)
      state_ff == ST_IDLE && blkStart
      |=> txValid_ff && txByte_ff == {3'h0, $past(lenByte_ff[4:0])};
   endproperty
   a_countFirst: assert property (p_countFirst) else $error("count not first");

   property p_rsvdByte;
      @(posedge clk_sys) disable iff (rst)
      state_ff != ST_IDLE && byteTaken && !hostNack && left_ff != 5'h00
      && rdIdx_ff == `CBCFG_IDX_RSVD |=> txByte_ff == `CBCFG_RSVD_VAL;
   endproperty
   a_rsvdByte: assert property (p_rsvdByte) else $error("byte 4 not ones");

   property p_nackEnds;
      @(posedge clk_sys) disable iff (rst)
      state_ff != ST_IDLE && hostNack |=> !txValid_ff && state_ff == ST_IDLE;
   endproperty
   a_nackEnds: assert property (p_nackEnds) else $error("nack ignored");

   property p_idRead;
      @(posedge clk_sys) disable iff (rst)
      state_ff != ST_IDLE && byteTaken && !hostNack && left_ff != 5'h00
      && rdIdx_ff == `CBCFG_IDX_REVVEN |=> txByte_ff == $past(rdByte);
   endproperty
   a_idRead: assert property (p_idRead) else $error("id byte wrong");
endmodule // cbcfg_bank

// file: sim/cbcfg_host_model.sv
/*
 Host controller model doing indexed block reads of the bank.
 Assumes the bank and its clock clk_sys; the bench calls blockRead.
*/
`timescale 1ns/1ps
module cbcfg_host_model (
   // Clock
   input  wire logic       clk_sys,
   // Block read control
   output logic            blkStart,
   output logic [7:0]      blkStartIdx,
   output logic            byteTaken,
   output logic            hostNack,
   // Block read data
   input  wire logic [7:0] txByte_ff,
   input  wire logic       txValid_ff
);
   initial begin
      {blkStart, byteTaken, hostNack} = 3'h0;
      blkStartIdx = 8'h00;
   end
   // A nonzero nackAt refuses that byte instead of acknowledging it.
   task automatic blockRead(input logic [7:0] idx, input logic [5:0] nackAt,
                            output logic [31:0][7:0] g, output logic [5:0] n);
      g = '0;
      n = 6'h00;
      @(negedge clk_sys);
      blkStart = 1'b1;
      blkStartIdx = idx;
      @(negedge clk_sys);
      blkStart = 1'b0;
      blkStartIdx = ~idx;
      @(negedge clk_sys);
      while (txValid_ff === 1'b1 && n < 6'h20) begin
         g[n] = txByte_ff;
         n = n + 6'h01;
         if (n == nackAt) begin
            hostNack = 1'b1;
         end else begin
            byteTaken = 1'b1;
         end
         @(negedge clk_sys);
         {byteTaken, hostNack} = 2'h0;
         @(negedge clk_sys);
      end
   endtask
endmodule // cbcfg_host_model

// file: sim/testbench.sv
/*
 Self-checking bench for the configuration bank.
 Assumes the package, the design and the host model compiled before it.
*/
`timescale 1ns/1ps
module testbench
   import cbcfg_pkg::*;
;
   logic             clk_sys = 1'b0;
   logic             rst = 1'b1;
   cbcfg_wr_t        wrReq = '0;
   logic             blkStart, byteTaken, hostNack, txValid_ff;
   logic [7:0]       blkStartIdx, txByte_ff;
   logic [7:0]       b3m = 8'h07, b7m = 8'h08;
   cbcfg_ctl_t       ctl_ff;
   int               n_fail = 0, tests_run = 0, cycles = 0;
   logic [24:0]      rows [8] = '{{8'h03, 8'h38, 9'h1C8}, {8'h03, 8'h01, 9'h028},
      {8'h03, 8'h19, 9'h028}, {8'h03, 8'h31, 9'h1A8}, {8'h07, 8'hE3, 9'h1A3},
      {8'h05, 8'h00, 9'h1A3}, {8'h04, 8'h00, 9'h1A3}, {8'h03, 8'hFE, 9'h1C3}};
   cbcfg_bank dut (.clk_sys(clk_sys), .rst(rst), .wrReq(wrReq), .blkStart(blkStart),
      .blkStartIdx(blkStartIdx), .byteTaken(byteTaken), .hostNack(hostNack),
      .txByte_ff(txByte_ff), .txValid_ff(txValid_ff), .ctl_ff(ctl_ff));
   cbcfg_host_model host (.clk_sys(clk_sys), .blkStart(blkStart),
      .blkStartIdx(blkStartIdx), .byteTaken(byteTaken), .hostNack(hostNack),
      .txByte_ff(txByte_ff), .txValid_ff(txValid_ff));
   always #5 clk_sys = ~clk_sys;
   task automatic complete_run();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         n_fail = n_fail + 1;
         $display("BAD %0t run hung", $time);
         complete_run();
      end
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      tests_run = tests_run + 1;
      if (seen !== exp) begin
         n_fail = n_fail + 1;
         $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      @(negedge clk_sys);
      wrReq = '{wrEn: 1'b1, idx: idx, data: d};
      @(negedge clk_sys);
      wrReq = '0;
      if (idx == 8'h03) b3m = (d & 8'h39) | 8'h06;
      if (idx == 8'h07) b7m = d & 8'h1F;
      @(negedge clk_sys);
   endtask
   // Identity bytes follow the design's default identity parameters.
   function automatic logic [7:0] expByte(input logic [7:0] i);
      case (i)
         8'h03: return b3m;
         8'h04: return 8'hFF;
         8'h05: return 8'hA5;
         8'h06: return 8'hAA;
         8'h07: return b7m;
         default: return 8'h00;
      endcase
   endfunction
   task automatic rd(input logic [7:0] idx, input logic [5:0] nackAt);
      logic [31:0][7:0] g;
      logic [5:0]       n, expN;
      // A proper host refuses the last byte it wants, so every read ends in a refusal.
      expN = (nackAt != 6'h00) ? nackAt : 6'(b7m[4:0]) + 6'h01;
      host.blockRead(idx, expN, g, n);
      check(16'(n), 16'(expN), "byte total");
      check(16'(g[0]), 16'(b7m), "count byte");
      for (int k = 1; k < int'(expN); k++) begin
         check(16'(g[k]), 16'(expByte(idx + 8'(k - 1))), "data byte");
      end
      $display("read from %h done", idx);
   endtask
   initial begin
      repeat (10) @(negedge clk_sys);
      rst = 1'b0;
      repeat (2) @(negedge clk_sys);
      foreach (rows[r]) begin
         wr(rows[r][24:17], rows[r][16:9]);
         check(16'(ctl_ff), 16'(rows[r][8:0]), "control");
      end
      $display("write rows done");
      rd(8'h03, 6'h00);
      rd(8'h05, 6'h02);
      wr(8'h07, 8'h20);
      rd(8'h06, 6'h00);
      wr(8'h07, 8'h1F);
      rd(8'h00, 6'h00);
      // A reset in mid-run must bring every stored byte back to its default.
      @(negedge clk_sys);
      rst = 1'b1;
      repeat (2) @(negedge clk_sys);
      check(16'(txValid_ff), 16'h0000, "valid in reset");
      rst = 1'b0;
      repeat (2) @(negedge clk_sys);
      check(16'(ctl_ff), 16'h0028, "control default");
      $display("reset test done");
      b3m = 8'h07;
      b7m = 8'h08;
      rd(8'h04, 6'h00);
      complete_run();
   end
endmodule // testbench
